// ===== uart_fifo_status_reset_rts.sv
// The address-and-strobe port was decided locally.
`timescale 1ns/10ps
// Operation
// RL1 - status bit 1 is 1 while tx fifo has room, 0 when full; resets 1
// RL2 - tx fifo entry count readable as read-only 16-bit value, resets to zero
// RL3 - rx fifo entry count readable as read-only 16-bit value, resets to zero
// RL4 - soft reset bit 2 empties tx fifo, same as tx flush in fifo control
// RL5 - soft reset bit 1 empties rx fifo, same as rx flush in fifo control
// RL6 - both flush bits clear themselves and read back as zero
// RL7 - soft reset bit 0 resets whole controller, async assert, sync release
// RL8 - rts mirror bit reads and writes modem control rts bit, resets 0
// RL9 - without auto flow, rts_n goes low while the rts bit is 1
// RL10 - auto flow with fifos on holds rts_n high above rx threshold
// RL11 - loopback holds rts_n high and loops rts back to modem status
// RL12 - fifo depth is a parameter, default 16, bounding counts and full
// RL13 - controller soft reset zeroes both counts and sets the room flag
module uart_fifo_status_reset_rts #(
	parameter int unsigned DEPTH = uart_fsr_pkg::FIFO_DEPTH
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// register port
	input wire logic [31:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	// fifo traffic from the data path
	input uart_fsr_pkg::fifo_evt_s fifo_evt,
	// controls to the data path
	output logic tx_flush,
	output logic rx_flush,
	output logic fifo_en,
	output logic uart_rst_n,
	// status
	output logic tx_room_flag,
	output logic [15:0] tx_level,
	output logic [15:0] rx_level,
	// modem side
	output logic rts_n,
	output logic loop_cts
);

	localparam logic [15:0] DEPTH_W = 16'(DEPTH);

	uart_fsr_pkg::ctrl_state_s s;
	uart_fsr_pkg::ctrl_state_s next_s;
	logic ur_hold;
	logic rst_comb_n;
	logic [uart_fsr_pkg::RST_SYNC_STAGES-1:0] rst_sync;
	logic wr_srr;
	logic wr_fcr;
	logic tx_clear;
	logic rx_clear;
	logic above;

	// one push/pop step, saturating at empty and at depth
	function automatic logic [15:0] step(
		input logic [15:0] cnt,
		input logic push,
		input logic pop,
		input logic [15:0] lim
	);
		logic okp;
		logic oko;
		okp = push && (cnt < lim);
		oko = pop && (cnt != 16'h0000);
		if (okp && !oko) begin
			step = 16'(cnt + 16'h0001);
		end else if (oko && !okp) begin
			step = 16'(cnt - 16'h0001);
		end else begin
			step = cnt;
		end
	endfunction : step

	////////////////////////////////////////////////////////////////////////
	// controller soft reset

	// pulse from a flop so the async assert cannot glitch
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ur_hold <= 1'b0;
		end else begin
			ur_hold <= wr && (addr == uart_fsr_pkg::ADDR_SOFT_RESET)
				&& wdata[uart_fsr_pkg::SR_BLOCK]; // [RL7]
		end
	end

	assign rst_comb_n = rst_n && !ur_hold; // [RL7]

	// release only on a clock edge; serial domain takes uart_rst_n too
	always_ff @(posedge clk_sys or negedge rst_comb_n) begin
		if (!rst_comb_n) begin
			rst_sync <= '0;
		end else begin
			rst_sync <= {rst_sync[uart_fsr_pkg::RST_SYNC_STAGES-2:0], 1'b1}; // [RL7]
		end
	end

	assign uart_rst_n = rst_sync[uart_fsr_pkg::RST_SYNC_STAGES-1];

	////////////////////////////////////////////////////////////////////////
	// next state

	assign wr_srr = wr && (addr == uart_fsr_pkg::ADDR_SOFT_RESET);
	assign wr_fcr = wr && (addr == uart_fsr_pkg::ADDR_FIFO_CTRL);

	always_comb begin
		next_s = s;
		next_s.rdata = 16'h0000;
		// dropping fifo enable also empties both fifos
		tx_clear = (wr_srr && wdata[uart_fsr_pkg::SR_TX_FLUSH])
			|| (wr_fcr && wdata[uart_fsr_pkg::FC_TX_FLUSH])
			|| (wr_fcr && s.fifo_en && !wdata[uart_fsr_pkg::FC_ENABLE]); // [RL4]
		rx_clear = (wr_srr && wdata[uart_fsr_pkg::SR_RX_FLUSH])
			|| (wr_fcr && wdata[uart_fsr_pkg::FC_RX_FLUSH])
			|| (wr_fcr && s.fifo_en && !wdata[uart_fsr_pkg::FC_ENABLE]); // [RL5]
		// flush strobes live one cycle only
		next_s.tx_flush = tx_clear; // [RL6]
		next_s.rx_flush = rx_clear; // [RL6]
		// a flush outranks traffic in the same cycle
		if (tx_clear) begin
			next_s.tx_cnt = uart_fsr_pkg::RST_COUNT; // [RL4]
		end else begin
			next_s.tx_cnt = step(s.tx_cnt, fifo_evt.tx_push, fifo_evt.tx_pop, DEPTH_W); // [RL2]
		end
		if (rx_clear) begin
			next_s.rx_cnt = uart_fsr_pkg::RST_COUNT; // [RL5]
		end else begin
			next_s.rx_cnt = step(s.rx_cnt, fifo_evt.rx_push, fifo_evt.rx_pop, DEPTH_W); // [RL3]
		end
		next_s.tx_room = (next_s.tx_cnt != DEPTH_W); // [RL1] [RL12]
		if (wr) begin
			case (addr)
				uart_fsr_pkg::ADDR_RTS_MIRROR: begin
					next_s.rts = wdata[0]; // [RL8]
				end
				uart_fsr_pkg::ADDR_MODEM_CTRL: begin
					next_s.rts = wdata[uart_fsr_pkg::MC_RTS];
					next_s.loop = wdata[uart_fsr_pkg::MC_LOOP];
					next_s.auto_flow = wdata[uart_fsr_pkg::MC_AUTO_FLOW];
				end
				uart_fsr_pkg::ADDR_FIFO_CTRL: begin
					next_s.fifo_en = wdata[uart_fsr_pkg::FC_ENABLE];
				end
				uart_fsr_pkg::ADDR_RX_THRESH: begin
					next_s.thresh = wdata[15:0];
				end
				default: begin
				end
			endcase
		end
		if (rd) begin
			case (addr)
				uart_fsr_pkg::ADDR_FIFO_STATUS: begin
					next_s.rdata[uart_fsr_pkg::ST_TX_ROOM] = s.tx_room; // [RL1]
					next_s.rdata[uart_fsr_pkg::ST_TX_EMPTY] = (s.tx_cnt == 16'h0000);
					next_s.rdata[uart_fsr_pkg::ST_RX_NOT_EMPTY] = (s.rx_cnt != 16'h0000);
					next_s.rdata[uart_fsr_pkg::ST_RX_FULL] = (s.rx_cnt == DEPTH_W);
				end
				uart_fsr_pkg::ADDR_TX_FILL: begin
					next_s.rdata = s.tx_cnt; // [RL2]
				end
				uart_fsr_pkg::ADDR_RX_FILL: begin
					next_s.rdata = s.rx_cnt; // [RL3]
				end
				uart_fsr_pkg::ADDR_RTS_MIRROR: begin
					next_s.rdata[0] = s.rts; // [RL8]
				end
				uart_fsr_pkg::ADDR_MODEM_CTRL: begin
					next_s.rdata[uart_fsr_pkg::MC_RTS] = s.rts;
					next_s.rdata[uart_fsr_pkg::MC_LOOP] = s.loop;
					next_s.rdata[uart_fsr_pkg::MC_AUTO_FLOW] = s.auto_flow;
				end
				uart_fsr_pkg::ADDR_FIFO_CTRL: begin
					// flush bits are write-only
					next_s.rdata[uart_fsr_pkg::FC_ENABLE] = s.fifo_en; // [RL6]
				end
				uart_fsr_pkg::ADDR_RX_THRESH: begin
					next_s.rdata = s.thresh;
				end
				default: begin
					next_s.rdata = 16'h0000;
				end
			endcase
		end
		above = next_s.auto_flow && next_s.fifo_en && (next_s.rx_cnt > next_s.thresh);
		if (next_s.loop) begin
			next_s.rts_n = 1'b1; // [RL11]
		end else begin
			next_s.rts_n = !(next_s.rts && !above); // [RL9] [RL10]
		end
		next_s.loop_cts = next_s.loop && next_s.rts; // [RL11]
	end

	////////////////////////////////////////////////////////////////////////
	// state register

	// everything here falls back with the controller soft reset
	always_ff @(posedge clk_sys or negedge uart_rst_n) begin
		if (!uart_rst_n) begin
			s.tx_cnt <= uart_fsr_pkg::RST_COUNT; // [RL13]
			s.rx_cnt <= uart_fsr_pkg::RST_COUNT; // [RL13]
			s.tx_room <= uart_fsr_pkg::RST_TX_ROOM; // [RL13]
			s.rts <= uart_fsr_pkg::RST_RTS;
			s.loop <= 1'b0;
			s.auto_flow <= 1'b0;
			s.fifo_en <= 1'b0;
			s.thresh <= uart_fsr_pkg::RST_THRESH;
			s.rdata <= 16'h0000;
			s.rts_n <= 1'b1;
			s.loop_cts <= 1'b0;
			s.tx_flush <= 1'b0;
			s.rx_flush <= 1'b0;
		end else begin
			s <= next_s;
		end
	end

	assign rdata = {16'h0000, s.rdata};
	assign tx_flush = s.tx_flush;
	assign rx_flush = s.rx_flush;
	assign fifo_en = s.fifo_en;
	assign tx_room_flag = s.tx_room;
	assign tx_level = s.tx_cnt;
	assign rx_level = s.rx_cnt;
	assign rts_n = s.rts_n;
	assign loop_cts = s.loop_cts;

	////////////////////////////////////////////////////////////////////////
	// checks

	a_tx_room_flag: assert property (@(posedge clk_sys) disable iff (!uart_rst_n) // [RL1]
		fifo_evt.tx_push && !fifo_evt.tx_pop && !tx_clear && (s.tx_cnt == DEPTH_W - 16'h0001)
		|=> !tx_room_flag && (tx_level == DEPTH_W))
		else $error("tx room flag not cleared at full");

	a_tx_level_read: assert property (@(posedge clk_sys) disable iff (!uart_rst_n) // [RL2]
		rd && (addr == uart_fsr_pkg::ADDR_TX_FILL)
		|=> rdata == {16'h0000, $past(s.tx_cnt)})
		else $error("tx level read mismatch");

	a_rx_level_read: assert property (@(posedge clk_sys) disable iff (!uart_rst_n) // [RL3]
		rd && (addr == uart_fsr_pkg::ADDR_RX_FILL)
		|=> rdata == {16'h0000, $past(s.rx_cnt)})
		else $error("rx level read mismatch");

	a_tx_flush_empty: assert property (@(posedge clk_sys) disable iff (!uart_rst_n) // [RL4]
		wr_srr && wdata[uart_fsr_pkg::SR_TX_FLUSH]
		|=> (tx_level == 16'h0000) && tx_room_flag && tx_flush)
		else $error("tx flush did not empty fifo");

	a_rx_flush_empty: assert property (@(posedge clk_sys) disable iff (!uart_rst_n) // [RL5]
		wr_srr && wdata[uart_fsr_pkg::SR_RX_FLUSH]
		|=> (rx_level == 16'h0000) && rx_flush)
		else $error("rx flush did not empty fifo");

	a_flush_self_clear: assert property (@(posedge clk_sys) disable iff (!uart_rst_n) // [RL6]
		tx_flush && !tx_clear |=> !tx_flush)
		else $error("tx flush stuck high");

	a_soft_reset_seq: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL7]
		wr_srr && wdata[uart_fsr_pkg::SR_BLOCK] && uart_rst_n
		|=> (!uart_rst_n)[*3] ##1 uart_rst_n)
		else $error("soft reset sequence wrong");

	a_rts_mirror_read: assert property (@(posedge clk_sys) disable iff (!uart_rst_n) // [RL8]
		wr && (addr == uart_fsr_pkg::ADDR_RTS_MIRROR) ##1 rd && (addr == uart_fsr_pkg::ADDR_RTS_MIRROR)
		|=> rdata[0] == $past(wdata[0], 2))
		else $error("rts mirror readback wrong");

	a_rts_manual: assert property (@(posedge clk_sys) disable iff (!uart_rst_n) // [RL9]
		wr && (addr == uart_fsr_pkg::ADDR_RTS_MIRROR) && wdata[0] && !s.loop && !s.auto_flow
		|=> !rts_n)
		else $error("rts_n not driven low");

	// rts_n is registered together with the settings it is derived from
	a_rts_flow_gate: assert property (@(posedge clk_sys) disable iff (!uart_rst_n) // [RL10]
		s.auto_flow && s.fifo_en && (s.rx_cnt > s.thresh)
		|-> rts_n)
		else $error("rts_n active above threshold");

	a_loop_hold: assert property (@(posedge clk_sys) disable iff (!uart_rst_n) // [RL11]
		s.loop && !wr |=> rts_n && (loop_cts == $past(s.rts)))
		else $error("loopback rts handling wrong");

	a_level_bound: assert property (@(posedge clk_sys) disable iff (!uart_rst_n) // [RL12]
		(tx_level <= DEPTH_W) && (rx_level <= DEPTH_W))
		else $error("fifo level beyond depth");

	a_reset_levels: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL13]
		$rose(uart_rst_n) |-> (tx_level == 16'h0000) && (rx_level == 16'h0000) && tx_room_flag)
		else $error("soft reset left fifo state");

endmodule : uart_fifo_status_reset_rts

// ===== uart_fsr_pkg.sv
package uart_fsr_pkg;

	// fifo geometry
	localparam int unsigned FIFO_DEPTH = 16;
	localparam int unsigned CNT_W = 16;

	// register byte addresses
	localparam logic [31:0] ADDR_FIFO_STATUS = 32'h5000_117C;
	localparam logic [31:0] ADDR_TX_FILL = 32'h5000_1180;
	localparam logic [31:0] ADDR_RX_FILL = 32'h5000_1184;
	localparam logic [31:0] ADDR_SOFT_RESET = 32'h5000_1188;
	localparam logic [31:0] ADDR_RTS_MIRROR = 32'h5000_118C;
	localparam logic [31:0] ADDR_MODEM_CTRL = 32'h5000_1200;
	localparam logic [31:0] ADDR_FIFO_CTRL = 32'h5000_1204;
	localparam logic [31:0] ADDR_RX_THRESH = 32'h5000_1208;

	// fifo_status fields
	localparam int unsigned ST_TX_ROOM = 1;
	localparam int unsigned ST_TX_EMPTY = 2;
	localparam int unsigned ST_RX_NOT_EMPTY = 3;
	localparam int unsigned ST_RX_FULL = 4;

	// soft_reset_ctrl fields
	localparam int unsigned SR_BLOCK = 0;
	localparam int unsigned SR_RX_FLUSH = 1;
	localparam int unsigned SR_TX_FLUSH = 2;

	// modem_control_reg fields
	localparam int unsigned MC_RTS = 1;
	localparam int unsigned MC_LOOP = 4;
	localparam int unsigned MC_AUTO_FLOW = 5;

	// fifo_control_reg fields
	localparam int unsigned FC_ENABLE = 0;
	localparam int unsigned FC_RX_FLUSH = 1;
	localparam int unsigned FC_TX_FLUSH = 2;

	// reset values
	localparam logic [15:0] RST_COUNT = 16'h0000;
	localparam logic RST_TX_ROOM = 1'b1;
	localparam logic RST_RTS = 1'b0;
	localparam logic [15:0] RST_THRESH = 16'h000E;

	// soft reset release: synchroniser stages
	localparam int unsigned RST_SYNC_STAGES = 2;

	typedef struct packed {
		logic tx_push;
		logic tx_pop;
		logic rx_push;
		logic rx_pop;
	} fifo_evt_s;

	typedef struct packed {
		logic [15:0] tx_cnt;
		logic [15:0] rx_cnt;
		logic tx_room;
		logic rts;
		logic loop;
		logic auto_flow;
		logic fifo_en;
		logic [15:0] thresh;
		logic [15:0] rdata;
		logic rts_n;
		logic loop_cts;
		logic tx_flush;
		logic rx_flush;
	} ctrl_state_s;

endpackage : uart_fsr_pkg

// ===== modem_peer.sv
`timescale 1ns/10ps
// data set on the far side: it only sends while the uart asks for data
module modem_peer (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// modem lines
	input wire logic rts_n,
	output logic may_send
);
	// registered so the peer reacts a cycle late, as a real set would
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			may_send <= 1'b0;
		end else begin
			may_send <= (rts_n === 1'b0);
		end
	end
endmodule : modem_peer

// ===== tb_top.sv
`timescale 1ns/10ps
module tb_top;
	localparam int unsigned DEP = 4;
	logic clk_sys, rst_n, wr, rd, tx_flush, rx_flush, fifo_en, uart_rst_n;
	logic tx_room_flag, rts_n, loop_cts, may_send;
	logic [31:0] addr, wdata, rdata;
	logic [15:0] tx_level, rx_level;
	uart_fsr_pkg::fifo_evt_s fifo_evt;
	int bad_count, total_checks;
	uart_fifo_status_reset_rts #(.DEPTH(DEP)) u_dut (.clk_sys(clk_sys), .rst_n(rst_n),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .fifo_evt(fifo_evt),
		.tx_flush(tx_flush), .rx_flush(rx_flush), .fifo_en(fifo_en), .uart_rst_n(uart_rst_n),
		.tx_room_flag(tx_room_flag), .tx_level(tx_level), .rx_level(rx_level),
		.rts_n(rts_n), .loop_cts(loop_cts));
	modem_peer u_peer (.clk_sys(clk_sys), .rst_n(rst_n), .rts_n(rts_n), .may_send(may_send));
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : tally_and_finish
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : cyc
	task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk_sys);
		wr <= 1'b0;
	endtask : wr_reg
	// read data stand only in the cycle after the strobe
	task automatic rd_chk(input string name, input logic [31:0] a, input logic [31:0] exp);
		@(posedge clk_sys);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk_sys);
		rd <= 1'b0;
		#1;
		check(name, rdata, exp);
	endtask : rd_chk
	task automatic pulse(input logic tx, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge clk_sys);
			fifo_evt.tx_push <= tx;
			fifo_evt.rx_push <= !tx;
		end
		@(posedge clk_sys);
		fifo_evt <= '0;
	endtask : pulse
	// counts flush strobes over the four edges after a write
	task automatic count_flush(output int n_tx, output int n_rx);
		n_tx = 0;
		n_rx = 0;
		repeat (4) begin
			@(posedge clk_sys);
			if (tx_flush === 1'b1) begin
				n_tx++;
			end
			if (rx_flush === 1'b1) begin
				n_rx++;
			end
		end
	endtask : count_flush
	// bounded wait for the controller reset to lift
	task automatic wait_up;
		for (int i = 0; i < 12; i++) begin
			@(posedge clk_sys);
			if (uart_rst_n === 1'b1) begin
				return;
			end
		end
		bad_count++;
		tally_and_finish();
	endtask : wait_up
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset_values;
		rd_chk("status", uart_fsr_pkg::ADDR_FIFO_STATUS, 32'h0000_0006);
		rd_chk("tx fill", uart_fsr_pkg::ADDR_TX_FILL, 32'h0000_0000);
		rd_chk("rx fill", uart_fsr_pkg::ADDR_RX_FILL, 32'h0000_0000);
		rd_chk("rts mirror", uart_fsr_pkg::ADDR_RTS_MIRROR, 32'h0000_0000);
		rd_chk("unmapped", 32'h5000_1190, 32'h0000_0000);
		wr_reg(uart_fsr_pkg::ADDR_TX_FILL, 32'h0000_0003);
		rd_chk("tx fill ro", uart_fsr_pkg::ADDR_TX_FILL, 32'h0000_0000);
	endtask : t_reset_values
	task automatic t_tx_fill;
		int nt;
		int nr;
		pulse(1'b1, DEP + 1);
		check("tx level full", {16'h0000, tx_level}, DEP);
		check("room full", tx_room_flag, 1'b0);
		rd_chk("status full", uart_fsr_pkg::ADDR_FIFO_STATUS, 32'h0000_0000);
		wr_reg(uart_fsr_pkg::ADDR_SOFT_RESET, 32'h0000_0004);
		count_flush(nt, nr);
		check("tx flush pulses", nt, 1);
		check("rx flush untouched", nr, 0);
		check("tx level flushed", {16'h0000, tx_level}, 32'h0000_0000);
		check("room flushed", tx_room_flag, 1'b1);
		rd_chk("soft reset reads", uart_fsr_pkg::ADDR_SOFT_RESET, 32'h0000_0000);
		pulse(1'b1, 2);
		wr_reg(uart_fsr_pkg::ADDR_FIFO_CTRL, 32'h0000_0004);
		rd_chk("tx fill fcr", uart_fsr_pkg::ADDR_TX_FILL, 32'h0000_0000);
	endtask : t_tx_fill
	task automatic t_rx_flush;
		int nt;
		int nr;
		pulse(1'b0, 3);
		rd_chk("rx fill", uart_fsr_pkg::ADDR_RX_FILL, 32'h0000_0003);
		rd_chk("status rx", uart_fsr_pkg::ADDR_FIFO_STATUS, 32'h0000_000E);
		wr_reg(uart_fsr_pkg::ADDR_SOFT_RESET, 32'h0000_0002);
		count_flush(nt, nr);
		check("rx flush pulses", nr, 1);
		check("tx flush untouched", nt, 0);
		rd_chk("rx fill flushed", uart_fsr_pkg::ADDR_RX_FILL, 32'h0000_0000);
	endtask : t_rx_flush
	task automatic t_rts;
		int nt;
		int nr;
		// write and read back to back, as the bus allows
		@(posedge clk_sys);
		wr <= 1'b1;
		addr <= uart_fsr_pkg::ADDR_RTS_MIRROR;
		wdata <= 32'h0000_0001;
		@(posedge clk_sys);
		wr <= 1'b0;
		rd <= 1'b1;
		@(posedge clk_sys);
		rd <= 1'b0;
		#1;
		check("mirror b2b", rdata, 32'h0000_0001);
		wr_reg(uart_fsr_pkg::ADDR_RTS_MIRROR, 32'h0000_0001);
		cyc(3);
		check("rts on", rts_n, 1'b0);
		check("peer may send", may_send, 1'b1);
		rd_chk("modem rts", uart_fsr_pkg::ADDR_MODEM_CTRL, 32'h0000_0002);
		wr_reg(uart_fsr_pkg::ADDR_MODEM_CTRL, 32'h0000_0012);
		cyc(3);
		check("rts loop", rts_n, 1'b1);
		check("loop cts", loop_cts, 1'b1);
		rd_chk("mirror loop", uart_fsr_pkg::ADDR_RTS_MIRROR, 32'h0000_0001);
		wr_reg(uart_fsr_pkg::ADDR_MODEM_CTRL, 32'h0000_0022);
		wr_reg(uart_fsr_pkg::ADDR_FIFO_CTRL, 32'h0000_0001);
		wr_reg(uart_fsr_pkg::ADDR_RX_THRESH, 32'h0000_0002);
		pulse(1'b0, 2);
		cyc(3);
		check("rts at thresh", rts_n, 1'b0);
		check("fifo en on", fifo_en, 1'b1);
		pulse(1'b0, 1);
		cyc(3);
		check("rts above", rts_n, 1'b1);
		check("loop off", loop_cts, 1'b0);
		wr_reg(uart_fsr_pkg::ADDR_SOFT_RESET, 32'h0000_0002);
		cyc(3);
		check("rts drained", rts_n, 1'b0);
		// dropping the fifo enable empties both fifos
		pulse(1'b0, 1);
		pulse(1'b1, 1);
		wr_reg(uart_fsr_pkg::ADDR_FIFO_CTRL, 32'h0000_0000);
		count_flush(nt, nr);
		check("drop en tx", nt, 1);
		check("drop en rx", nr, 1);
		check("fifo en off", fifo_en, 1'b0);
		check("drop en rx level", {16'h0000, rx_level}, 32'h0000_0000);
		check("drop en tx level", {16'h0000, tx_level}, 32'h0000_0000);
	endtask : t_rts
	task automatic t_soft_reset;
		pulse(1'b1, 2);
		pulse(1'b0, 1);
		wr_reg(uart_fsr_pkg::ADDR_SOFT_RESET, 32'h0000_0001);
		#1;
		check("ctrl reset low", uart_rst_n, 1'b0);
		wait_up();
		check("tx level", {16'h0000, tx_level}, 32'h0000_0000);
		check("rx level", {16'h0000, rx_level}, 32'h0000_0000);
		check("room", tx_room_flag, 1'b1);
		check("rts idle", rts_n, 1'b1);
		rd_chk("mirror cleared", uart_fsr_pkg::ADDR_RTS_MIRROR, 32'h0000_0000);
	endtask : t_soft_reset
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		rst_n = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = 32'h0000_0000;
		wdata = 32'h0000_0000;
		fifo_evt = '0;
		bad_count = 0;
		total_checks = 0;
		cyc(20);
		rst_n <= 1'b1;
		wait_up();
		t_reset_values();
		t_tx_fill();
		t_rx_flush();
		t_rts();
		t_soft_reset();
		tally_and_finish();
	end
endmodule : tb_top
